/* File: shared/bfkm_pkg.sv */
// Constants, register map and types for the B-field keystream mixer
package bfkm_pkg;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0] REG_CTRL    = 8'h00;
   localparam logic [7:0] REG_SEGLEN  = 8'h04;
   localparam logic [7:0] REG_QBITS   = 8'h08;
   localparam logic [7:0] REG_RATIO   = 8'h0C;
   localparam logic [7:0] REG_SUBCNT  = 8'h10;
   localparam logic [7:0] REG_DATALEN = 8'h14;
   localparam logic [7:0] REG_CRCLEN  = 8'h18;
   localparam logic [7:0] REG_STATUS  = 8'h1C;
   localparam logic [7:0] REG_COUNT   = 8'h20;

   // Control field positions
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_FMT_LSB   = 1;
   localparam int CTRL_CFG_LSB   = 4;
   localparam int CTRL_RX_BIT    = 7;
   localparam int STAT_BUSY_BIT  = 0;
   localparam int STAT_DONE_BIT  = 1;

   // Reset values
   localparam logic [10:0] SEGLEN_RST  = 11'h690;   // 1680 bit segments
   localparam logic [11:0] QBITS_RST   = 12'h000;
   localparam logic [3:0]  RATIO_RST   = 4'h1;
   localparam logic [5:0]  SUBCNT_RST  = 6'h08;
   localparam logic [11:0] DATALEN_RST = 12'h040;
   localparam logic [4:0]  CRCLEN_RST  = 5'h10;
   localparam logic [1:0]  FMT_RST     = 2'h0;
   localparam logic [2:0]  CFG_RST     = 3'h0;

   // Protection formats
   localparam logic [1:0] FMT_MULTI    = 2'h0;
   localparam logic [1:0] FMT_CONST    = 2'h1;
   localparam logic [1:0] FMT_ENCODED  = 2'h2;

   // Modulation configurations
   localparam logic [2:0] CFG_1A               = 3'h0;
   localparam logic [2:0] CFG_1B               = 3'h1;
   localparam logic [2:0] CFG_2                = 3'h2;
   localparam logic [2:0] CFG_3                = 3'h3;
   localparam logic [2:0] CFG_CONFIG_OFFSET80  = 3'h4;
   localparam logic [2:0] CFG_CONFIG_OFFSET120 = 3'h5;
   localparam logic [2:0] CFG_5                = 3'h6;
   localparam logic [2:0] CFG_6                = 3'h7;

   // Keystream offsets and subfield geometry
   localparam logic [6:0]  OFF_BASE   = 7'h28;       // 40
   localparam logic [6:0]  OFF_80     = 7'h50;       // 80
   localparam logic [6:0]  OFF_120    = 7'h78;       // 120
   localparam logic [15:0] SUB_BITS   = 16'h0040;    // 64 data bits
   localparam logic [15:0] SUB_GAP    = 16'h0010;    // 80 stride minus 64

   typedef enum logic [2:0] {
      PH_IDLE,
      PH_LEAD,
      PH_DATA,
      PH_GAP,
      PH_TAIL
   } bfkm_phase_e;

endpackage : bfkm_pkg

/* File: src/bfkm_offset_sel.sv */
// Keystream offset and B-field bit count selection per configuration
`timescale 1ns/10ps
module bfkm_offset_sel
   import bfkm_pkg::*;
(
   input  wire logic [2:0]  cfg,          // Modulation configuration
   input  wire logic [10:0] seg_len,      // Segment length maximum
   input  wire logic [11:0] q_user,       // Software q for offset80/120
   output logic      [6:0]  offset,       // First used keystream bit
   output logic      [11:0] q_eff         // Effective B-field bit count
);

   // Offset 80 and 120 configurations, otherwise 40
   always_comb begin
      if (cfg == CFG_CONFIG_OFFSET80) begin
         offset = OFF_80;
      end else if (cfg == CFG_CONFIG_OFFSET120) begin
         offset = OFF_120;
      end else begin
         offset = OFF_BASE;
      end
   end

   always_comb begin
      if (cfg == CFG_CONFIG_OFFSET80 || cfg == CFG_CONFIG_OFFSET120) begin
         q_eff = q_user;
      end else begin
         q_eff = {1'b0, seg_len} - {5'h00, OFF_BASE};
      end
   end

endmodule : bfkm_offset_sel

/* File: src/bfkm_mixer.sv */
// B-field keystream mixer: bit-serial XOR of payload with keystream segment
`timescale 1ns/10ps
module bfkm_mixer
   import bfkm_pkg::*;
(
   input  wire logic        clk_sys,      // System clock, 10 MHz
   input  wire logic        rst_n,        // Async reset, active low
   input  wire logic [7:0]  reg_addr,     // Register byte address
   input  wire logic [31:0] reg_wdata,    // Register write data
   input  wire logic        reg_wr,       // Write strobe
   input  wire logic        reg_rd,       // Read strobe
   output logic      [31:0] reg_rdata,    // Read data, cycle after strobe
   input  wire logic        key_valid,    // Keystream bit offered
   input  wire logic        key_bit,      // Keystream bit
   output logic             key_ready,    // Keystream bit taken
   input  wire logic        pl_valid,     // Payload bit offered
   input  wire logic        pl_bit,       // Payload bit
   output logic             pl_ready,     // Payload bit taken
   output logic             out_valid,    // Mixed bit pulse
   output logic             out_bit,      // Mixed bit
   output logic             busy          // Burst in progress
);

   typedef struct packed {
      bfkm_phase_e phase;
      logic [10:0] seg_cnt;
      logic [15:0] bit_cnt;
      logic [5:0]  sub_cnt;
      logic [15:0] used_cnt;
      logic        done;
      logic        out_valid;
      logic        out_bit;
      logic [31:0] rdata;
      logic [1:0]  fmt;
      logic [2:0]  cfg;
      logic        rx;
      logic [10:0] seg_len;
      logic [11:0] q_user;
      logic [3:0]  ratio;
      logic [5:0]  sub_num;
      logic [11:0] data_len;
      logic [4:0]  crc_len;
   } bfkm_state_s;

   bfkm_state_s st_reg;
   bfkm_state_s st_next;

   logic [6:0]  offset;
   logic [11:0] q_eff;
   logic [15:0] enc_len;
   logic [15:0] data_len_now;
   logic [15:0] gap_len_now;
   logic        active;
   logic        need_pl;
   logic        step;
   logic        seg_wrap;
   logic        bit_end;
   logic        lead_done;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Offset and q selection
   bfkm_offset_sel u_sel (
      .cfg     (st_reg.cfg),
      .seg_len (st_reg.seg_len),
      .q_user  (st_reg.q_user),
      .offset  (offset),
      .q_eff   (q_eff)
   );

   assign enc_len = {4'h0, q_eff} * {12'h000, st_reg.ratio};

   // Lengths of the current data and gap runs
   always_comb begin
      case (st_reg.fmt)
         FMT_ENCODED: data_len_now = enc_len;
         FMT_CONST:   data_len_now = {4'h0, st_reg.data_len};
         default:     data_len_now = SUB_BITS;
      endcase
      gap_len_now = (st_reg.fmt == FMT_CONST) ? {11'h000, st_reg.crc_len} : SUB_GAP;
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Stream handshake
   assign active    = (st_reg.phase != PH_IDLE);
   assign need_pl   = (st_reg.phase == PH_DATA) ||
                      (st_reg.phase == PH_GAP && st_reg.fmt == FMT_CONST);
   assign key_ready = active && (!need_pl || pl_valid);
   assign pl_ready  = need_pl && key_valid;
   assign step      = active && key_valid && (!need_pl || pl_valid);
   assign seg_wrap  = ({5'h00, st_reg.seg_cnt} + 16'h0001) >= {5'h00, st_reg.seg_len};
   assign bit_end   = (st_reg.bit_cnt + 16'h0001) >= ((st_reg.phase == PH_LEAD) ?
                      {9'h000, offset} : (st_reg.phase == PH_DATA) ? data_len_now : gap_len_now);
   assign lead_done = step && (st_reg.phase == PH_LEAD) && bit_end;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      st_next           = st_reg;
      st_next.out_valid = 1'b0;
      st_next.rdata     = 32'h0000_0000;

      // Register writes
      if (reg_wr) begin
         case (reg_addr)
            REG_CTRL: begin
               st_next.fmt = reg_wdata[CTRL_FMT_LSB +: 2];
               st_next.cfg = reg_wdata[CTRL_CFG_LSB +: 3];
               st_next.rx  = reg_wdata[CTRL_RX_BIT];
               if (reg_wdata[CTRL_START_BIT] && !active) begin
                  st_next.phase    = PH_LEAD;
                  st_next.seg_cnt  = 11'h000;
                  st_next.bit_cnt  = 16'h0000;
                  st_next.sub_cnt  = 6'h00;
                  st_next.used_cnt = 16'h0000;
                  st_next.done     = 1'b0;
               end
            end
            REG_SEGLEN:  st_next.seg_len  = reg_wdata[10:0];
            REG_QBITS:   st_next.q_user   = reg_wdata[11:0];
            REG_RATIO:   st_next.ratio    = reg_wdata[3:0];
            REG_SUBCNT:  st_next.sub_num  = reg_wdata[5:0];
            REG_DATALEN: st_next.data_len = reg_wdata[11:0];
            REG_CRCLEN:  st_next.crc_len  = reg_wdata[4:0];
            default: ;
         endcase
      end

      // Register reads, unmapped reads as zero
      if (reg_rd) begin
         case (reg_addr)
            REG_CTRL:    st_next.rdata = {24'h000000, st_reg.rx, st_reg.cfg, 1'b0,
                                          st_reg.fmt, 1'b0};
            REG_SEGLEN:  st_next.rdata = {21'h000000, st_reg.seg_len};
            REG_QBITS:   st_next.rdata = {20'h00000, st_reg.q_user};
            REG_RATIO:   st_next.rdata = {28'h0000000, st_reg.ratio};
            REG_SUBCNT:  st_next.rdata = {26'h0000000, st_reg.sub_num};
            REG_DATALEN: st_next.rdata = {20'h00000, st_reg.data_len};
            REG_CRCLEN:  st_next.rdata = {27'h0000000, st_reg.crc_len};
            REG_STATUS:  st_next.rdata = {30'h00000000, st_reg.done, active};
            REG_COUNT:   st_next.rdata = {16'h0000, st_reg.used_cnt};
            default:     st_next.rdata = 32'h0000_0000;
         endcase
      end

      // Bit step
      if (step) begin
         st_next.seg_cnt = seg_wrap ? 11'h000 : st_reg.seg_cnt + 11'h001;
         st_next.bit_cnt = bit_end ? 16'h0000 : st_reg.bit_cnt + 16'h0001;
         st_next.out_valid = need_pl;
         st_next.out_bit   = need_pl ? (pl_bit ^ ((st_reg.phase == PH_DATA) & key_bit)) :
                             st_reg.out_bit;
         if (st_reg.phase == PH_DATA) begin
            st_next.used_cnt = st_reg.used_cnt + 16'h0001;
         end
         case (st_reg.phase)
            PH_LEAD: begin
               if (bit_end) begin
                  st_next.phase = PH_DATA;
               end
            end
            PH_DATA: begin
               if (bit_end) begin
                  if (st_reg.fmt == FMT_ENCODED) begin
                     st_next.phase = seg_wrap ? PH_IDLE : PH_TAIL;
                     st_next.done  = seg_wrap;
                  end else begin
                     st_next.phase = PH_GAP;
                  end
               end
            end
            PH_GAP: begin
               if (bit_end) begin
                  if ({10'h000, st_reg.sub_cnt} + 16'h0001 >= {10'h000, st_reg.sub_num}) begin
                     st_next.phase = seg_wrap ? PH_IDLE : PH_TAIL;
                     st_next.done  = seg_wrap;
                  end else begin
                     st_next.phase   = PH_DATA;
                     st_next.sub_cnt = st_reg.sub_cnt + 6'h01;
                  end
               end
            end
            PH_TAIL: begin
               if (seg_wrap) begin
                  st_next.phase = PH_IDLE;
                  st_next.done  = 1'b1;
               end
            end
            default: st_next.phase = PH_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_reg          <= '0;
         st_reg.phase    <= PH_IDLE;
         st_reg.fmt      <= FMT_RST;
         st_reg.cfg      <= CFG_RST;
         st_reg.seg_len  <= SEGLEN_RST;
         st_reg.q_user   <= QBITS_RST;
         st_reg.ratio    <= RATIO_RST;
         st_reg.sub_num  <= SUBCNT_RST;
         st_reg.data_len <= DATALEN_RST;
         st_reg.crc_len  <= CRCLEN_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs
   assign reg_rdata = st_reg.rdata;
   assign out_valid = st_reg.out_valid;
   assign out_bit   = st_reg.out_bit;
   assign busy      = active;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_lead_end;
      lead_done;
   endsequence

   sequence s_mix_step;
      step && st_reg.phase == PH_DATA;
   endsequence

   property p_off40;
      @(posedge clk_sys) disable iff (!rst_n)
      (s_lead_end and (st_reg.cfg != CFG_CONFIG_OFFSET80 && st_reg.cfg != CFG_CONFIG_OFFSET120))
      |=> (st_reg.seg_cnt == 11'h028) && (st_reg.phase == PH_DATA);
   endproperty
   a_off40: assert property (p_off40) else $error("first mixed bit not at 40");

   property p_off80;
      @(posedge clk_sys) disable iff (!rst_n)
      (s_lead_end and (st_reg.cfg == CFG_CONFIG_OFFSET80)) |=> st_reg.seg_cnt == 11'h050;
   endproperty
   a_off80: assert property (p_off80) else $error("first mixed bit not at 80");

   property p_off120;
      @(posedge clk_sys) disable iff (!rst_n)
      (s_lead_end and (st_reg.cfg == CFG_CONFIG_OFFSET120)) |=> st_reg.seg_cnt == 11'h078;
   endproperty
   a_off120: assert property (p_off120) else $error("first mixed bit not at 120");

   property p_mix;
      @(posedge clk_sys) disable iff (!rst_n)
      s_mix_step |=> out_valid && (out_bit == ($past(pl_bit) ^ $past(key_bit)));
   endproperty
   a_mix: assert property (p_mix) else $error("payload bit not mixed with key bit");

   property p_crc_pass;
      @(posedge clk_sys) disable iff (!rst_n)
      (step && st_reg.phase == PH_GAP && st_reg.fmt == FMT_CONST)
      |=> out_valid && (out_bit == $past(pl_bit));
   endproperty
   a_crc_pass: assert property (p_crc_pass) else $error("CRC bit altered");

   property p_tail;
      @(posedge clk_sys) disable iff (!rst_n)
      (st_reg.phase == PH_TAIL) |-> !pl_ready ##1 !out_valid;
   endproperty
   a_tail: assert property (p_tail) else $error("payload taken during discard");

   property p_wrap;
      @(posedge clk_sys) disable iff (!rst_n)
      (step && seg_wrap) |=> st_reg.seg_cnt == 11'h000;
   endproperty
   a_wrap: assert property (p_wrap) else $error("segment index did not wrap");

   property p_q;
      @(posedge clk_sys) disable iff (!rst_n)
      (st_reg.cfg != CFG_CONFIG_OFFSET80 && st_reg.cfg != CFG_CONFIG_OFFSET120)
      |-> q_eff == ({1'b0, st_reg.seg_len} - 12'h028);
   endproperty
   a_q: assert property (p_q) else $error("q not segment length minus 40");

   property p_enc_end;
      @(posedge clk_sys) disable iff (!rst_n)
      (s_mix_step and (st_reg.fmt == FMT_ENCODED && bit_end))
      |=> (st_reg.phase == PH_TAIL || st_reg.phase == PH_IDLE) && st_reg.used_cnt == $past(enc_len);
   endproperty
   a_enc_end: assert property (p_enc_end) else $error("encoded run length wrong");

endmodule : bfkm_mixer

/* File: bench/bfkm_far_model.sv */
// Far-side model: keystream source and payload source for the mixer
`timescale 1ns/10ps
module bfkm_far_model (
   input  wire logic        clk_sys,     // System clock
   input  wire logic        rst_n,       // Async reset, active low
   input  wire logic        slow,        // Idle cycle after each taken bit
   input  wire logic        key_ready,   // Mixer takes keystream bit
   input  wire logic        pl_ready,    // Mixer takes payload bit
   output logic             key_valid,   // Keystream bit offered
   output logic             key_bit,     // Keystream bit
   output logic             pl_valid,    // Payload bit offered
   output logic             pl_bit,      // Payload bit
   output logic      [31:0] key_cnt,     // Keystream bits taken
   output logic      [31:0] pl_cnt       // Payload bits taken
);
   logic        valid_reg;
   logic [31:0] key_cnt_reg;
   logic [31:0] pl_cnt_reg;

   // Keystream pattern by index
   function automatic logic key_pat(input logic [31:0] k);
      logic [31:0] h;
      h = k * 32'h0000_9E37;
      return ^h[12:5];
   endfunction : key_pat

   // Payload pattern by index
   function automatic logic pl_pat(input logic [31:0] k);
      logic [31:0] h;
      h = k * 32'h0000_6B43;
      return ^h[11:3];
   endfunction : pl_pat

   // Offer held until taken, optional idle cycle after each take
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         valid_reg   <= 1'b0;
         key_cnt_reg <= 32'h0000_0000;
         pl_cnt_reg  <= 32'h0000_0000;
      end else begin
         if (key_valid && key_ready) key_cnt_reg <= key_cnt_reg + 32'h0000_0001;
         if (pl_valid && pl_ready) pl_cnt_reg <= pl_cnt_reg + 32'h0000_0001;
         valid_reg <= !(slow && key_valid && key_ready);
      end
   end

   // Idle lines show the inverse pattern, never a stale value
   assign key_valid = valid_reg;
   assign pl_valid  = valid_reg;
   assign key_bit   = valid_reg ? key_pat(key_cnt_reg) : ~key_pat(key_cnt_reg);
   assign pl_bit    = valid_reg ? pl_pat(pl_cnt_reg) : ~pl_pat(pl_cnt_reg);
   assign key_cnt   = key_cnt_reg;
   assign pl_cnt    = pl_cnt_reg;
endmodule : bfkm_far_model

/* File: bench/bfkm_mixer_tb.sv */
// Self-checking testbench for the B-field keystream mixer
`timescale 1ns/10ps
module bfkm_mixer_tb;
   import bfkm_pkg::*;
   localparam int SEG_BITS = 1680;
   logic        clk_sys, rst_n, reg_wr, reg_rd, key_valid, key_bit, key_ready;
   logic        pl_valid, pl_bit, pl_ready, out_valid, out_bit, busy, far_slow;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, key_cnt, pl_cnt;
   int          err_total, checked;
   logic        got_q[$];

   bfkm_mixer uut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .key_valid(key_valid), .key_bit(key_bit), .key_ready(key_ready),
      .pl_valid(pl_valid), .pl_bit(pl_bit), .pl_ready(pl_ready),
      .out_valid(out_valid), .out_bit(out_bit), .busy(busy));
   bfkm_far_model far (.clk_sys(clk_sys), .rst_n(rst_n), .slow(far_slow),
      .key_ready(key_ready), .pl_ready(pl_ready), .key_valid(key_valid), .key_bit(key_bit),
      .pl_valid(pl_valid), .pl_bit(pl_bit), .key_cnt(key_cnt), .pl_cnt(pl_cnt));

   // Clock, 100 ns period
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   // Collect mixed bits
   always @(posedge clk_sys) begin
      if (out_valid === 1'b1) got_q.push_back(out_bit);
   end

   task automatic give_verdict;
      $display("counts: checked %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd

   // One burst: program, start, wait, compare against the mapping
   task automatic burst(input logic [1:0] fmt, input logic [2:0] cfg, input int nsub,
         input int dlen, input int clen, input int qb, input int r, input logic rx,
         input logic poke);
      int          off, kb, pb, k, p, x, i, w;
      logic [31:0] d, ctrl;
      logic        exp_q[$];
      off = (cfg == CFG_CONFIG_OFFSET80) ? 80 : (cfg == CFG_CONFIG_OFFSET120) ? 120 : 40;
      if (fmt == FMT_ENCODED) begin
         nsub = 1;
         clen = 0;
         dlen = ((off == 40) ? SEG_BITS - 40 : qb) * r;
      end
      wr(REG_SUBCNT, 32'(nsub));
      wr(REG_DATALEN, 32'(dlen));
      wr(REG_CRCLEN, 32'(clen));
      wr(REG_QBITS, 32'(qb));
      wr(REG_RATIO, 32'(r));
      wr(REG_SEGLEN, 32'(SEG_BITS));
      kb = int'(key_cnt);
      pb = int'(pl_cnt);
      got_q.delete();
      ctrl = 32'h1 | (32'(fmt) << CTRL_FMT_LSB) | (32'(cfg) << CTRL_CFG_LSB)
         | (32'(rx) << CTRL_RX_BIT);
      wr(REG_CTRL, ctrl);
      if (poke) begin
         repeat (10) @(posedge clk_sys);
         wr(REG_CTRL, ctrl);
      end
      #1;
      for (w = 0; w < 8000 && busy !== 1'b0; w++) @(posedge clk_sys);
      if (busy !== 1'b0) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, busy, 1'b0);
         give_verdict();
      end
      repeat (3) @(posedge clk_sys);
      k = kb + off;
      p = pb;
      for (x = 0; x < nsub; x++) begin
         for (i = 0; i < dlen; i++) begin
            exp_q.push_back(far.pl_pat(32'(p)) ^ far.key_pat(32'(k)));
            p++;
            k++;
         end
         for (i = 0; i < clen; i++) begin
            if (fmt == FMT_CONST) begin
               exp_q.push_back(far.pl_pat(32'(p)));
               p++;
            end
            k++;
         end
      end
      chk(32'(got_q.size()), 32'(exp_q.size()));
      for (i = 0; i < exp_q.size(); i++) chk({31'h0, got_q[i]}, {31'h0, exp_q[i]});
      chk(key_cnt - 32'(kb), 32'(SEG_BITS));
      chk(pl_cnt - 32'(pb), 32'(p - pb));
      rd(REG_COUNT, d);
      chk(d, 32'(nsub * dlen));
      rd(REG_STATUS, d);
      chk(d, 32'h0000_0002);
   endtask : burst

   task automatic t_regs;
      logic [7:0]  a[9] = '{REG_SEGLEN, REG_QBITS, REG_RATIO, REG_SUBCNT, REG_DATALEN,
                            REG_CRCLEN, REG_STATUS, REG_COUNT, 8'h24};
      logic [31:0] e[9] = '{32'h690, 32'h0, 32'h1, 32'h8, 32'h40, 32'h10, 32'h0, 32'h0, 32'h0};
      logic [31:0] d;
      wr(8'h24, 32'hFFFF_FFFF);
      for (int i = 0; i < 9; i++) begin
         rd(a[i], d);
         chk(d, e[i]);
      end
      $display("test regs done, mismatches %0d", err_total);
   endtask : t_regs

   task automatic t_multi;
      for (int c = 0; c < 8; c++) begin
         burst(FMT_MULTI, 3'(c), 2, 64, 16, 0, 1, 1'b0, 1'b0);
      end
      far_slow <= 1'b1;
      burst(FMT_MULTI, CFG_1B, 20, 64, 16, 0, 1, 1'b0, 1'b0);
      far_slow <= 1'b0;
      burst(FMT_MULTI, CFG_CONFIG_OFFSET120, 19, 64, 16, 0, 1, 1'b0, 1'b0);
      $display("test multi done, mismatches %0d", err_total);
   endtask : t_multi

   task automatic t_const;
      burst(FMT_CONST, CFG_3, 3, 20, 16, 0, 1, 1'b0, 1'b0);
      burst(FMT_CONST, CFG_CONFIG_OFFSET80, 2, 64, 8, 0, 1, 1'b0, 1'b0);
      $display("test const done, mismatches %0d", err_total);
   endtask : t_const

   task automatic t_encoded;
      burst(FMT_ENCODED, CFG_2, 0, 0, 0, 0, 1, 1'b0, 1'b0);
      burst(FMT_ENCODED, CFG_CONFIG_OFFSET80, 0, 0, 0, 100, 3, 1'b0, 1'b0);
      far_slow <= 1'b1;
      burst(FMT_ENCODED, CFG_CONFIG_OFFSET120, 0, 0, 0, 50, 2, 1'b0, 1'b0);
      far_slow <= 1'b0;
      $display("test encoded done, mismatches %0d", err_total);
   endtask : t_encoded

   task automatic t_rx;
      burst(FMT_MULTI, CFG_5, 4, 64, 16, 0, 1, 1'b1, 1'b1);
      $display("test receive done, mismatches %0d", err_total);
   endtask : t_rx

   // Main sequence
   initial begin
      err_total = 0;
      checked   = 0;
      rst_n     = 1'b0;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 32'h0000_0000;
      far_slow  = 1'b0;
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_regs();
      t_multi();
      t_const();
      t_encoded();
      t_rx();
      give_verdict();
   end
endmodule : bfkm_mixer_tb
